/* File: design/mhb_pkg.sv */
// shared constants and types for the multiplexed host bus port.
// assumes both ends run on mclk (25 MHz) with synchronous active-high rst.
package mhb_pkg;
    localparam int BUS_W = 16;
    localparam int ADDR_W = 11;
    localparam int BE_W = 4;
    localparam int ADDR_HI_LSB = 2;
    localparam int BE_LSB = 12;
    localparam int HI8_W = 3;
    // host strobe low time, in ns and cycles
    localparam int STROBE_NS = 80;
    localparam int CLK_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
    localparam logic [BE_W-1:0] BE_RST = 4'h0;
    localparam logic WAKE_POL_RST = 1'b0;
    typedef enum logic [1:0] {
        MHB_ADDR_LO,
        MHB_ADDR_HI
    } mhb_aphase_e;
endpackage

/* File: design/mhb_if.sv */
// pins between host and device, plus resolved shared bus wires.
// assumes the testbench or board ties pull-ups on the strobes.
interface mhb_if;
    logic chipSelectN;
    logic cmdSelect;
    logic readStrobeN;
    logic writeStrobeN;
    logic [15:0] hostBusOut;
    logic hostBusOe;
    logic [15:0] devBusOut;
    logic devBusOe;
    logic [15:0] sharedBus;
    logic interruptN;
    logic wakeEventOut;
    // resolve the shared bus; idle lines read as zero
    assign sharedBus = hostBusOe ? hostBusOut : (devBusOe ? devBusOut : 16'h0000);
    modport host (
        output chipSelectN, cmdSelect, readStrobeN, writeStrobeN, hostBusOut, hostBusOe,
        input sharedBus, interruptN, wakeEventOut
    );
    modport device (
        input chipSelectN, cmdSelect, readStrobeN, writeStrobeN, sharedBus,
        output devBusOut, devBusOe, interruptN, wakeEventOut
    );
endinterface

/* File: design/mhb_device.sv */
// device end: decodes address and data phases from host strobes.
// assumes strobes synchronous to mclk; a data write/read is a user pulse.
module mhb_device (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link
    mhb_if.device bus,
    // user side configuration
    input wire logic busMode16,
    input wire logic wakePolWr,
    input wire logic wakePolIn,
    // user side events
    input wire logic irqStatus,
    input wire logic wakeDetect,
    input wire logic wakeClear,
    // user side access
    output logic [10:0] accAddr,
    output logic [3:0] accBe,
    output logic [15:0] wrData,
    output logic wrStrobe,
    output logic rdStrobe,
    input wire logic [15:0] rdData
);
    logic [10:0] addr_r;
    logic [3:0] be_r;
    logic [15:0] wrData_r;
    logic wrLow_r;
    logic rdLow_r;
    logic wakePol_r;
    logic wake_r;
    logic [15:0] rdHold_r;
    mhb_pkg::mhb_aphase_e aphase_r;
    logic sel;
    logic wrFall;
    logic rdFall;

    assign sel = !bus.chipSelectN;
    assign wrFall = sel && !bus.writeStrobeN && !wrLow_r;
    assign rdFall = sel && !bus.readStrobeN && !rdLow_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrLow_r <= 1'b0;
            rdLow_r <= 1'b0;
        end else begin
            wrLow_r <= sel && !bus.writeStrobeN;
            rdLow_r <= sel && !bus.readStrobeN;
        end
    end

    // address phase capture, held until the next one
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_r <= mhb_pkg::ADDR_RST;
            be_r <= mhb_pkg::BE_RST;
            aphase_r <= mhb_pkg::MHB_ADDR_LO;
        end else if (wrFall && bus.cmdSelect) begin
            if (busMode16) begin
                addr_r <= {bus.sharedBus[10:2], 2'b00};
                be_r <= bus.sharedBus[15:12];
            end else if (aphase_r == mhb_pkg::MHB_ADDR_LO) begin
                addr_r[7:0] <= bus.sharedBus[7:0];
                aphase_r <= mhb_pkg::MHB_ADDR_HI;
            end else begin
                addr_r[10:8] <= bus.sharedBus[2:0];
                aphase_r <= mhb_pkg::MHB_ADDR_LO;
            end
        end else if (wrFall || rdFall) begin
            // a data access restarts the 8-bit address pair
            aphase_r <= mhb_pkg::MHB_ADDR_LO;
        end
    end

    // data phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            wrData_r <= 16'h0000;
        end else if (wrFall && !bus.cmdSelect) begin
            wrData_r <= busMode16 ? bus.sharedBus : {8'h00, bus.sharedBus[7:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdHold_r <= 16'h0000;
        end else if (rdFall && !bus.cmdSelect) begin
            rdHold_r <= busMode16 ? rdData : {8'h00, rdData[7:0]};
        end
    end

    // bus driven only while a selected data read is in progress
    assign bus.devBusOut = rdHold_r;
    // follows the live strobe, so the bus is freed on the cycle it rises
    assign bus.devBusOe = sel && !bus.readStrobeN && rdLow_r && !bus.cmdSelect;
    assign accAddr = addr_r;
    assign accBe = be_r;
    assign wrData = wrData_r;
    assign wrStrobe = wrFall && !bus.cmdSelect;
    assign rdStrobe = rdFall && !bus.cmdSelect;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wakePol_r <= mhb_pkg::WAKE_POL_RST;
        end else if (wakePolWr) begin
            wakePol_r <= wakePolIn;
        end
    end

    // set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else if (wakeDetect) begin
            wake_r <= 1'b1;
        end else if (wakeClear) begin
            wake_r <= 1'b0;
        end
    end

    assign bus.wakeEventOut = wake_r ? wakePol_r : !wakePol_r;
    assign bus.interruptN = !irqStatus;
endmodule // mhb_device

/* File: design/mhb_host.sv */
// host end: turns user requests into address and data cycles.
// assumes device on the same mclk; one request at a time.
module mhb_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // link
    mhb_if.host bus,
    // user side request
    input wire logic busMode16,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [10:0] reqAddr,
    input wire logic [3:0] reqBe,
    input wire logic [15:0] reqData,
    output logic reqReady,
    output logic [15:0] rspData,
    output logic rspValid,
    output logic irqActive
);
    typedef enum logic [2:0] {
        MHB_IDLE,
        MHB_ADR1,
        MHB_GAP1,
        MHB_ADR2,
        MHB_GAP2,
        MHB_DATA,
        MHB_GAP3
    } mhb_hstate_e;

    // request state
    mhb_hstate_e state_r;
    mhb_hstate_e state_nxt;
    logic [1:0] cnt_r;
    logic write_r;
    logic mode16_r;
    logic [2:0] addrHi_r;
    logic [15:0] data_r;
    // pin registers
    logic csN_r;
    logic cmd_r;
    logic rdN_r;
    logic wrN_r;
    logic [15:0] busOut_r;
    logic busOe_r;
    // user side results
    logic [15:0] rsp_r;
    logic rspValid_r;
    logic irq_r;
    // phase events
    logic take;
    logic low;
    logic last;
    logic endStrobe;
    logic startAdr2;
    logic startData;
    logic [15:0] adrWord1;
    logic [15:0] adrWord2;
    logic [15:0] dataWord;

    assign take = reqValid && (state_r == MHB_IDLE);
    assign low = (state_r == MHB_ADR1) || (state_r == MHB_ADR2) || (state_r == MHB_DATA);
    assign last = cnt_r == 2'(mhb_pkg::STROBE_CYC - 1);
    assign endStrobe = low && last;
    // 8-bit mode needs the upper address write before any data access
    assign startAdr2 = (state_r == MHB_GAP1) && !mode16_r;
    assign startData = ((state_r == MHB_GAP1) && mode16_r) || (state_r == MHB_GAP2);
    // first word built from the request itself, as it is driven on the accepting edge
    assign adrWord1 = busMode16 ? {reqBe, 1'b0, reqAddr[10:2], 2'b00}
        : {8'h00, reqAddr[7:0]};
    assign adrWord2 = {13'h0, addrHi_r};
    assign dataWord = mode16_r ? data_r : {8'h00, data_r[7:0]};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MHB_IDLE: begin
                if (reqValid) begin
                    state_nxt = MHB_ADR1;
                end
            end
            MHB_ADR1: begin
                if (last) begin
                    state_nxt = MHB_GAP1;
                end
            end
            MHB_GAP1: begin
                state_nxt = mode16_r ? MHB_DATA : MHB_ADR2;
            end
            MHB_ADR2: begin
                if (last) begin
                    state_nxt = MHB_GAP2;
                end
            end
            MHB_GAP2: begin
                state_nxt = MHB_DATA;
            end
            MHB_DATA: begin
                if (last) begin
                    state_nxt = MHB_GAP3;
                end
            end
            default: begin
                state_nxt = MHB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= MHB_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // strobe low time counted from its first low cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 2'h0;
        end else if (low && !last) begin
            cnt_r <= cnt_r + 2'h1;
        end else begin
            cnt_r <= 2'h0;
        end
    end

    // request fields kept for the later phases; mode frozen per request
    always_ff @(posedge mclk) begin
        if (rst) begin
            write_r <= 1'b0;
            mode16_r <= 1'b0;
            addrHi_r <= 3'h0;
            data_r <= 16'h0000;
        end else if (take) begin
            write_r <= reqWrite;
            mode16_r <= busMode16;
            addrHi_r <= reqAddr[10:8];
            data_r <= reqData;
        end
    end

    // chip select framed with every strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            csN_r <= 1'b1;
        end else if (take || startAdr2 || startData) begin
            csN_r <= 1'b0;
        end else if (endStrobe) begin
            csN_r <= 1'b1;
        end
    end

    // command high for each address write (one in 16-bit mode, two in 8-bit mode), low for data
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_r <= 1'b0;
        end else if (take || startAdr2) begin
            cmd_r <= 1'b1;
        end else if (startData) begin
            cmd_r <= 1'b0;
        end
    end

    // every address and data write carries its own write strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            wrN_r <= 1'b1;
        end else if (take || startAdr2) begin
            wrN_r <= 1'b0;
        end else if (startData) begin
            wrN_r <= !write_r;
        end else if (endStrobe) begin
            wrN_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdN_r <= 1'b1;
        end else if (startData) begin
            rdN_r <= write_r;
        end else if (endStrobe) begin
            rdN_r <= 1'b1;
        end
    end

    // bus word set on the strobe's edge and held through it
    always_ff @(posedge mclk) begin
        if (rst) begin
            busOut_r <= 16'h0000;
        end else if (take) begin
            busOut_r <= adrWord1;
        end else if (startAdr2) begin
            busOut_r <= adrWord2;
        end else if (startData) begin
            busOut_r <= write_r ? dataWord : 16'h0000;
        end
    end

    // released for reads and between strobes, so the ends never fight
    always_ff @(posedge mclk) begin
        if (rst) begin
            busOe_r <= 1'b0;
        end else if (take || startAdr2) begin
            busOe_r <= 1'b1;
        end else if (startData) begin
            busOe_r <= write_r;
        end else if (endStrobe) begin
            busOe_r <= 1'b0;
        end
    end

    // read word taken on the last low cycle, while the device still drives
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_r <= 16'h0000;
        end else if (endStrobe && (state_r == MHB_DATA) && !write_r) begin
            rsp_r <= mode16_r ? bus.sharedBus : {8'h00, bus.sharedBus[7:0]};
        end
    end

    // completion pulse for reads and writes alike
    always_ff @(posedge mclk) begin
        if (rst) begin
            rspValid_r <= 1'b0;
        end else begin
            rspValid_r <= endStrobe && (state_r == MHB_DATA);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= !bus.interruptN;
        end
    end

    assign reqReady = state_r == MHB_IDLE;
    assign rspData = rsp_r;
    assign rspValid = rspValid_r;
    assign irqActive = irq_r;
    assign bus.chipSelectN = csN_r;
    assign bus.cmdSelect = cmd_r;
    assign bus.readStrobeN = rdN_r;
    assign bus.writeStrobeN = wrN_r;
    assign bus.hostBusOut = busOut_r;
    assign bus.hostBusOe = busOe_r;
endmodule // mhb_host

/* File: verification/mhb_bus_monitor.sv */
// checker for the host bus pins between the two ends.
// assumes instantiation beside the interface, on mclk.
module mhb_bus_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus pins
    input wire logic chipSelectN,
    input wire logic cmdSelect,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic hostBusOe,
    input wire logic devBusOe,
    input wire logic [15:0] sharedBus
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    strobe_needs_cs_a: assert property (!(readStrobeN && writeStrobeN) |-> !chipSelectN)
        else $error("strobe without chip select");
    strobes_apart_a: assert property (readStrobeN || writeStrobeN)
        else $error("read and write strobe together");
    read_data_only_a: assert property (!readStrobeN |-> !cmdSelect)
        else $error("read in address phase");
    bus_no_fight_a: assert property (!(hostBusOe && devBusOe))
        else $error("both ends drive the bus");
    dev_drive_read_a: assert property (devBusOe |-> !readStrobeN && !chipSelectN)
        else $error("device drives outside read");
    write_host_drives_a: assert property (!writeStrobeN |-> hostBusOe)
        else $error("write strobe with bus released");
    write_pulse_width_a: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*2])
        else $error("write strobe too short");
    read_pulse_width_a: assert property ($fell(readStrobeN) |-> !readStrobeN [*2])
        else $error("read strobe too short");
    write_bus_stable_a: assert property (!writeStrobeN && !$past(writeStrobeN)
        |-> $stable(sharedBus) && $stable(cmdSelect))
        else $error("bus moved under write strobe");
endmodule // mhb_bus_monitor

/* File: verification/muxed_host_bus_port_test.sv */
// bench joining host and device ends through the bus interface.
// assumes valid/ready request side and pulsed device accesses.
module muxed_host_bus_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst = 1'b1, busMode16 = 1'b1, wakePolWr = 1'b0, wakePolIn = 1'b0;
    logic irqStatus = 1'b0, wakeDetect = 1'b0, wakeClear = 1'b0, reqValid = 1'b0;
    logic reqWrite = 1'b0, reqReady, rspValid, irqActive, wrStrobe, rdStrobe, prevWrN = 1'b1;
    logic [10:0] reqAddr = 11'h000, accAddr, gotAddr;
    logic [3:0] reqBe = 4'h0, accBe, gotBe;
    logic [15:0] reqData = 16'h0000, rdData = 16'h0000, rspData, wrData, rsp;
    logic [15:0] aBus0, aBus1;
    int devCount = 0, errors = 0, samplesChecked = 0;
    mhb_if mhb_if_i ();
    mhb_host mhb_host_i (.mclk, .rst, .bus(mhb_if_i.host), .busMode16, .reqValid, .reqWrite,
        .reqAddr, .reqBe, .reqData, .reqReady, .rspData, .rspValid, .irqActive);
    mhb_device mhb_device_i (.mclk, .rst, .bus(mhb_if_i.device), .busMode16, .wakePolWr,
        .wakePolIn, .irqStatus, .wakeDetect, .wakeClear, .accAddr, .accBe, .wrData, .wrStrobe,
        .rdStrobe, .rdData);
    mhb_bus_monitor mhb_bus_monitor_i (.mclk, .rst, .chipSelectN(mhb_if_i.chipSelectN),
        .cmdSelect(mhb_if_i.cmdSelect), .readStrobeN(mhb_if_i.readStrobeN),
        .writeStrobeN(mhb_if_i.writeStrobeN), .hostBusOe(mhb_if_i.hostBusOe),
        .devBusOe(mhb_if_i.devBusOe), .sharedBus(mhb_if_i.sharedBus));
    initial begin
        forever #20 mclk = ~mclk;
    end
    // address phases as seen on the wire, newest in aBus0
    always @(posedge mclk) begin
        prevWrN <= mhb_if_i.writeStrobeN;
        if (prevWrN && !mhb_if_i.writeStrobeN && mhb_if_i.cmdSelect) begin
            aBus1 <= aBus0;
            aBus0 <= mhb_if_i.sharedBus;
        end
        if (wrStrobe || rdStrobe) begin
            devCount <= devCount + 1;
            gotAddr <= accAddr;
            gotBe <= accBe;
        end
    end
    task automatic finish_test();
        if (errors == 0 && samplesChecked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one request; ready taken at the edge after a negedge that saw it high
    task automatic access(input logic wr, input logic [10:0] a, input logic [3:0] be,
        input logic [15:0] d);
        int n;
        int start;
        start = devCount;
        @(negedge mclk);
        {reqValid, reqWrite, reqAddr, reqBe, reqData} = {1'b1, wr, a, be, d};
        for (n = 0; reqReady !== 1'b1; n++) begin
            if (n == 300) begin
                errors++;
                finish_test();
            end
            @(negedge mclk);
        end
        @(negedge mclk);
        reqValid = 1'b0;
        // completion pulse ends reads and writes alike
        for (n = 0; rspValid !== 1'b1; n++) begin
            if (n == 300) begin
                errors++;
                finish_test();
            end
            @(negedge mclk);
        end
        rsp = rspData;
        check("dev strobes", 16'(devCount - start), 16'h0001);
    endtask
    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        access(1'b1, 11'h7fc, 4'ha, 16'hbeef);
        check("addr16 bus", {aBus0[15:12], 1'b0, aBus0[10:2], 2'b0}, 16'ha7fc);
        check("acc addr16", {5'h0, gotAddr[10:2], 2'b0}, 16'h07fc);
        check("acc be", {12'h0, gotBe}, 16'h000a);
        check("wr data16", wrData, 16'hbeef);
        rdData = 16'h1234;
        access(1'b0, 11'h404, 4'h3, 16'h0000);
        check("rd data16", rsp, 16'h1234);
        check("rd addr16", {5'h0, gotAddr[10:2], 2'b0}, 16'h0404);
        busMode16 = 1'b0;
        access(1'b1, 11'h5a3, 4'h1, 16'h33c6);
        check("addr8 first", {8'h0, aBus1[7:0]}, 16'h00a3);
        check("addr8 second", {13'h0, aBus0[2:0]}, 16'h0005);
        check("addr8 upper", {aBus1[15:8], aBus0[15:8]}, 16'h0000);
        check("acc addr8", {5'h0, gotAddr}, 16'h05a3);
        check("wr data8", wrData, 16'h00c6);
        rdData = 16'hffe7;
        access(1'b0, 11'h2ff, 4'h1, 16'h0000);
        check("rd data8", rsp, 16'h00e7);
        check("rd addr8", {5'h0, gotAddr}, 16'h02ff);
        irqStatus = 1'b1;
        settle();
        check("irq pin", {14'h0, mhb_if_i.interruptN, irqActive}, 16'h0001);
        irqStatus = 1'b0;
        wakeDetect = 1'b1;
        settle();
        check("irq off wake low", {14'h0, mhb_if_i.interruptN, irqActive}, 16'h0002);
        check("wake default", {15'h0, mhb_if_i.wakeEventOut}, 16'h0000);
        {wakeDetect, wakeClear} = 2'b01;
        settle();
        check("wake idle", {15'h0, mhb_if_i.wakeEventOut}, 16'h0001);
        {wakeClear, wakePolIn, wakePolWr} = 3'b011;
        @(negedge mclk);
        {wakePolWr, wakeDetect} = 2'b01;
        settle();
        check("wake high", {15'h0, mhb_if_i.wakeEventOut}, 16'h0001);
        {wakeDetect, wakeClear} = 2'b01;
        settle();
        check("wake idle high", {15'h0, mhb_if_i.wakeEventOut}, 16'h0000);
        {wakeDetect, wakeClear} = 2'b11;
        settle();
        check("wake set wins", {15'h0, mhb_if_i.wakeEventOut}, 16'h0001);
        finish_test();
    end
endmodule // muxed_host_bus_port_test
